// >>> logic/nvdr_pkg.sv
// constants for the nonvolatile default register bank
package nvdr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] NVDR_OFS_ALERT_MASK_FIRST  = 8'h22;
  localparam logic [7:0] NVDR_OFS_ALERT_MASK_SECOND = 8'h23;
  localparam logic [7:0] NVDR_OFS_FAULT_RECORD      = 8'h24;
  localparam logic [7:0] NVDR_OFS_ADC_ALARM_RECORD  = 8'h25;
  localparam logic [7:0] NVDR_OFS_SWITCH_FAULT_TMO  = 8'h26;
  localparam logic [7:0] NVDR_OFS_AUX_PIN_SETUP     = 8'h27;
  localparam logic [7:0] NVDR_OFS_AUX_VOLT_LOW      = 8'h28;
  localparam logic [7:0] NVDR_OFS_AUX_VOLT_HIGH     = 8'h29;
  localparam logic [7:0] NVDR_OFS_SRC_VOLT_LOW      = 8'h2a;
  localparam logic [7:0] NVDR_OFS_SRC_VOLT_HIGH     = 8'h2b;
  localparam logic [7:0] NVDR_OFS_SHUNT_VOLT_LOW    = 8'h2c;
  localparam logic [7:0] NVDR_OFS_SHUNT_VOLT_HIGH   = 8'h2d;
  localparam logic [7:0] NVDR_OFS_WATTS_LOW         = 8'h2e;
  localparam logic [7:0] NVDR_OFS_WATTS_HIGH        = 8'h2f;
  localparam int         NVDR_NUM_BYTES             = 14;

  // ==========================================================
  // shipped contents
  localparam logic [7:0] NVDR_RST_LOW  = 8'h00;
  localparam logic [7:0] NVDR_RST_HIGH = 8'hff;
  localparam logic [NVDR_NUM_BYTES-1:0][7:0] NVDR_RST_IMAGE = {
    NVDR_RST_HIGH, NVDR_RST_LOW,  // watts high, low
    NVDR_RST_HIGH, NVDR_RST_LOW,  // shunt volt high, low
    NVDR_RST_HIGH, NVDR_RST_LOW,  // source volt high, low
    NVDR_RST_HIGH, NVDR_RST_LOW,  // aux volt high, low
    NVDR_RST_LOW,                 // aux pin setup
    NVDR_RST_HIGH,                // switch fault timeout
    NVDR_RST_LOW,  NVDR_RST_LOW,  // adc alarm record, fault record
    NVDR_RST_LOW,  NVDR_RST_LOW   // alert masks
  };
  localparam logic [7:0] NVDR_RST_READ = 8'h00;

  // ==========================================================
  // timing
  localparam int NVDR_MCLK_KHZ       = 10000;
  localparam int NVDR_NV_WRITE_US    = 1000;
  localparam int NVDR_NV_WRITE_CYC   = NVDR_NV_WRITE_US * NVDR_MCLK_KHZ / 1000;
  localparam int NVDR_REBOOT_MS      = 3200;
  localparam int NVDR_REBOOT_CYC     = NVDR_REBOOT_MS * NVDR_MCLK_KHZ;
  localparam int NVDR_WR_CNT_W       = 16;
  localparam int NVDR_BOOT_CNT_W     = 26;

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    NVDR_ST_BOOT = 3'b001,
    NVDR_ST_RUN  = 3'b010,
    NVDR_ST_OFF  = 3'b100
  } nvdr_state_t;

endpackage

// >>> logic/nvdr_bank.sv
// nonvolatile default register bank with event log capture
`timescale 1ns/100ps
`default_nettype none

module nvdr_bank
  import nvdr_pkg::*;
#(
  parameter int NV_WRITE_CYC = nvdr_pkg::NVDR_NV_WRITE_CYC,
  parameter int REBOOT_CYC   = nvdr_pkg::NVDR_REBOOT_CYC
) (
  // clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   reset,
  // register port from the serial interface
  input  wire logic [7:0]                             reg_addr,
  input  wire logic [7:0]                             reg_wdata,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output var  logic [7:0]                             reg_rdata,
  output var  logic                                   reg_rvalid,
  output var  logic                                   reg_hit,
  output var  logic                                   wr_refused,
  // volatile records and control from the core
  input  wire logic [7:0]                             fault_record,
  input  wire logic [7:0]                             adc_alarm_record,
  input  wire logic                                   fault_log_en,
  input  wire logic                                   restore_fault_en,
  input  wire logic                                   reboot_req,
  input  wire logic                                   restart_en,
  // defaults and sequencing toward the core
  output var  logic [nvdr_pkg::NVDR_NUM_BYTES-1:0][7:0] nv_image,
  output var  logic                                   load_defaults,
  output var  logic                                   restore_fault,
  output var  logic                                   host_ready,
  output var  logic                                   core_off,
  output var  logic                                   restart,
  output var  logic                                   nv_busy
);
  import nvdr_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    // sequencer
    nvdr_state_t                       state;
    logic [NVDR_BOOT_CNT_W-1:0]        boot_cnt;
    // bank contents and log edge detect
    logic [NVDR_NUM_BYTES-1:0][7:0]    nv;
    logic [7:0]                        flt_prev;
    logic [7:0]                        adc_prev;
    logic                              flt_pend;
    logic                              adc_pend;
    // write engine
    logic                              busy;
    logic [NVDR_WR_CNT_W-1:0]          wr_cnt;
    // host answers
    logic [7:0]                        rdata;
    logic                              rvalid;
    logic                              hit;
    logic                              refused;
    // core sequencing
    logic                              load;
    logic                              restore;
    logic                              ready;
    logic                              off;
    logic                              restart;
  } nvdr_regs_t;

  // ==========================================================
  // reset contents
  // shipped bank image
  localparam nvdr_regs_t NVDR_RST_REGS = '{
    state:    NVDR_ST_BOOT,
    boot_cnt: '0,
    nv:       NVDR_RST_IMAGE,
    flt_prev: NVDR_RST_LOW,
    adc_prev: NVDR_RST_LOW,
    flt_pend: 1'b0,
    adc_pend: 1'b0,
    busy:     1'b0,
    wr_cnt:   '0,
    rdata:    NVDR_RST_READ,
    rvalid:   1'b0,
    hit:      1'b0,
    refused:  1'b0,
    load:     1'b0,
    restore:  1'b0,
    ready:    1'b0,
    off:      1'b0,
    restart:  1'b0
  };

  nvdr_regs_t q;
  nvdr_regs_t d;

  // ==========================================================
  // slots and counter end points
  // slot of each byte inside the packed image
  localparam logic [3:0] SLOT_MASK_FIRST =
    4'(NVDR_OFS_ALERT_MASK_FIRST - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_MASK_SECOND =
    4'(NVDR_OFS_ALERT_MASK_SECOND - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_FAULT =
    4'(NVDR_OFS_FAULT_RECORD - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_ADC =
    4'(NVDR_OFS_ADC_ALARM_RECORD - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_SW_TMO =
    4'(NVDR_OFS_SWITCH_FAULT_TMO - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_PIN_SETUP =
    4'(NVDR_OFS_AUX_PIN_SETUP - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_AUX_LOW =
    4'(NVDR_OFS_AUX_VOLT_LOW - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_AUX_HIGH =
    4'(NVDR_OFS_AUX_VOLT_HIGH - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_SRC_LOW =
    4'(NVDR_OFS_SRC_VOLT_LOW - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_SRC_HIGH =
    4'(NVDR_OFS_SRC_VOLT_HIGH - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_SHUNT_LOW =
    4'(NVDR_OFS_SHUNT_VOLT_LOW - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_SHUNT_HIGH =
    4'(NVDR_OFS_SHUNT_VOLT_HIGH - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_WATTS_LOW =
    4'(NVDR_OFS_WATTS_LOW - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [3:0] SLOT_WATTS_HIGH =
    4'(NVDR_OFS_WATTS_HIGH - NVDR_OFS_ALERT_MASK_FIRST);
  localparam logic [NVDR_WR_CNT_W-1:0] WR_LAST =
    NVDR_WR_CNT_W'(NV_WRITE_CYC - 1);
  localparam logic [NVDR_BOOT_CNT_W-1:0] BOOT_LAST =
    NVDR_BOOT_CNT_W'(REBOOT_CYC - 1);

  // ==========================================================
  // address decode
  function automatic logic in_bank(input logic [7:0] a);
    in_bank = (a >= NVDR_OFS_ALERT_MASK_FIRST) && (a <= NVDR_OFS_WATTS_HIGH);
  endfunction

  // one arm per byte so each offset lands on its own slot
  function automatic logic [3:0] bank_idx(input logic [7:0] a);
    unique case (a)
      NVDR_OFS_ALERT_MASK_FIRST:  bank_idx = SLOT_MASK_FIRST;
      NVDR_OFS_ALERT_MASK_SECOND: bank_idx = SLOT_MASK_SECOND;
      NVDR_OFS_FAULT_RECORD:      bank_idx = SLOT_FAULT;
      NVDR_OFS_ADC_ALARM_RECORD:  bank_idx = SLOT_ADC;
      NVDR_OFS_SWITCH_FAULT_TMO:  bank_idx = SLOT_SW_TMO;
      NVDR_OFS_AUX_PIN_SETUP:     bank_idx = SLOT_PIN_SETUP;
      NVDR_OFS_AUX_VOLT_LOW:      bank_idx = SLOT_AUX_LOW;
      NVDR_OFS_AUX_VOLT_HIGH:     bank_idx = SLOT_AUX_HIGH;
      NVDR_OFS_SRC_VOLT_LOW:      bank_idx = SLOT_SRC_LOW;
      NVDR_OFS_SRC_VOLT_HIGH:     bank_idx = SLOT_SRC_HIGH;
      NVDR_OFS_SHUNT_VOLT_LOW:    bank_idx = SLOT_SHUNT_LOW;
      NVDR_OFS_SHUNT_VOLT_HIGH:   bank_idx = SLOT_SHUNT_HIGH;
      NVDR_OFS_WATTS_LOW:         bank_idx = SLOT_WATTS_LOW;
      NVDR_OFS_WATTS_HIGH:        bank_idx = SLOT_WATTS_HIGH;
      default:                    bank_idx = SLOT_MASK_FIRST;
    endcase
  endfunction

  function automatic logic rising(input logic [7:0] cur,
                                  input logic [7:0] prev);
    rising = |(cur & ~prev);
  endfunction

  // a log event needs the enable and a bit going high
  function automatic logic log_event(input logic       en,
                                     input logic [7:0] cur,
                                     input logic [7:0] prev);
    log_event = en && rising(cur, prev);
  endfunction

  // hand one byte to the write engine and open its busy window
  function automatic nvdr_regs_t start_write(input nvdr_regs_t s,
                                             input logic [3:0] idx,
                                             input logic [7:0] val);
    nvdr_regs_t r;
    r         = s;
    r.nv[idx] = val;
    r.busy    = 1'b1;
    r.wr_cnt  = '0;
    return r;
  endfunction

  // boot load, reboot entry and the timed restart
  function automatic nvdr_regs_t seq_step(input nvdr_regs_t s,
                                          input logic       restore_en,
                                          input logic       reboot,
                                          input logic       go_en);
    nvdr_regs_t r;
    r = s;
    unique case (s.state)
      NVDR_ST_BOOT: begin
        r.load  = 1'b1;
        r.ready = 1'b1;
        r.state = NVDR_ST_RUN;
        r.restore = restore_en;
      end
      NVDR_ST_RUN: begin
        if (reboot) begin
          r.state    = NVDR_ST_OFF;
          r.off      = 1'b1;
          r.load     = 1'b1;
          r.boot_cnt = '0;
        end
      end
      NVDR_ST_OFF: begin
        r.boot_cnt = s.boot_cnt + 1'b1;
        if (s.boot_cnt == BOOT_LAST) begin
          r.state   = NVDR_ST_RUN;
          r.off     = 1'b0;
          r.restart = go_en;
        end
      end
      default: begin
        r.state = NVDR_ST_BOOT;
      end
    endcase
    return r;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic host_wr;
    logic host_hit;
    host_wr  = 1'b0;
    host_hit = 1'b0;

    // pulses drop unless something below raises them
    d          = q;
    d.load     = 1'b0;
    d.restore  = 1'b0;
    d.restart  = 1'b0;
    d.rvalid   = 1'b0;
    d.refused  = 1'b0;
    d.flt_prev = fault_record;
    d.adc_prev = adc_alarm_record;

    // sequencer
    d = seq_step(d, restore_fault_en, reboot_req, restart_en);

    // host access, gated until the first load is done
    host_hit = q.ready && in_bank(reg_addr);
    host_wr  = reg_wr && host_hit;
    if (reg_rd && q.ready) begin
      d.rvalid = 1'b1;
      d.hit    = host_hit;
      d.rdata  = host_hit ? q.nv[bank_idx(reg_addr)] : NVDR_RST_READ;
    end

    // write engine, log copies ahead of host writes
    if (q.busy) begin
      d.wr_cnt = q.wr_cnt + 1'b1;
      if (q.wr_cnt == WR_LAST) begin
        d.busy = 1'b0;
      end
      // host write while busy is dropped and flagged
      d.refused = host_wr;
    end else if (q.flt_pend) begin
      d          = start_write(d, SLOT_FAULT, fault_record);
      d.flt_pend = 1'b0;
      d.refused  = host_wr;
    end else if (q.adc_pend) begin
      d          = start_write(d, SLOT_ADC, adc_alarm_record);
      d.adc_pend = 1'b0;
      d.refused  = host_wr;
    end else if (host_wr) begin
      d = start_write(d, bank_idx(reg_addr), reg_wdata);
    end

    // log only when enabled on a rising bit, set wins
    if (log_event(fault_log_en, fault_record, q.flt_prev)) begin
      d.flt_pend = 1'b1;
    end
    if (log_event(fault_log_en, adc_alarm_record, q.adc_prev)) begin
      d.adc_pend = 1'b1;
    end
  end

  // ==========================================================
  // registers, shipped contents on reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= NVDR_RST_REGS;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  // register answers
  assign reg_rdata     = q.rdata;
  assign reg_rvalid    = q.rvalid;
  assign reg_hit       = q.hit;
  assign wr_refused    = q.refused;

  assign nv_image      = q.nv;

  assign load_defaults = q.load;
  assign restore_fault = q.restore;
  assign host_ready    = q.ready;
  assign core_off      = q.off;
  assign restart       = q.restart;

  assign nv_busy       = q.busy;

endmodule

`default_nettype wire

// >>> bench/nvdr_props.sv
// assertions on the ports of the nv default register bank
`timescale 1ns/100ps
`default_nettype none
module nvdr_props #(
  parameter int NV_WRITE_CYC = 8
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        reg_rvalid,
  input wire logic        wr_refused,
  // core side
  input wire logic [7:0]  fault_record,
  input wire logic        fault_log_en,
  input wire logic        restore_fault_en,
  input wire logic        reboot_req,
  input wire logic [nvdr_pkg::NVDR_NUM_BYTES-1:0][7:0] nv_image,
  input wire logic        load_defaults,
  input wire logic        restore_fault,
  input wire logic        host_ready,
  input wire logic        core_off,
  input wire logic        nv_busy
);
  logic [15:0] busy_cnt_q;
  logic        in_bank;
  // ==========================================================
  // helpers
  assign in_bank = reg_addr inside {[8'h22:8'h2f]};
  always_ff @(posedge mclk) busy_cnt_q <= nv_busy ? busy_cnt_q + 16'h1 : 16'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_rise;
    fault_log_en && (fault_record & ~$past(fault_record)) != 8'h00;
  endsequence
  sequence s_copy;
    ##1 nv_busy && nv_image[2] == $past(fault_record);
  endsequence
  // ==========================================================
  // properties
  a_read_answer: assert property (
    reg_rd && host_ready |=> reg_rvalid) else $error("read unanswered");
  a_rvalid_cause: assert property (
    reg_rvalid |-> $past(reg_rd) && $past(host_ready))
    else $error("stray read answer");
  a_write_starts: assert property (
    reg_wr && host_ready && !nv_busy && in_bank |=> nv_busy || wr_refused)
    else $error("write not started");
  a_write_refused: assert property (
    reg_wr && host_ready && nv_busy && in_bank |=> wr_refused)
    else $error("busy write not refused");
  a_busy_length: assert property (
    $fell(nv_busy) |-> busy_cnt_q == 16'(NV_WRITE_CYC))
    else $error("busy length wrong");
  a_boot_load: assert property (
    $fell(reset) |=> load_defaults && host_ready &&
      restore_fault == $past(restore_fault_en)) else $error("boot load");
  a_reboot_start: assert property (
    reboot_req && host_ready && !core_off |=> core_off && load_defaults)
    else $error("reboot not started");
  a_fault_copy: assert property (
    s_rise and (!nv_busy && !reg_wr) |=> s_copy) else $error("no log copy");
endmodule
bind nvdr_bank nvdr_props #(.NV_WRITE_CYC(NV_WRITE_CYC)) nvdr_props_inst (
  .mclk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_rvalid, .wr_refused,
  .fault_record, .fault_log_en, .restore_fault_en, .reboot_req, .nv_image,
  .load_defaults, .restore_fault, .host_ready, .core_off, .nv_busy);
`default_nettype wire

// >>> bench/nvdr_host.sv
// host model on the byte register port
`timescale 1ns/100ps
`default_nettype none
module nvdr_host (
  // clock and answers
  input  wire logic       mclk,
  input  wire logic       nv_busy,
  input  wire logic       reg_rvalid,
  input  wire logic [7:0] reg_rdata,
  // requests
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit poll);
    for (int i = 0; i < 40 && poll && nv_busy !== 1'b0; i++) @(posedge mclk);
    @(posedge mclk);
    #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge mclk);
    #1 {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk);
    #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge mclk);
    #1 {reg_addr, reg_rd} = {~a, 1'b0};
    q = reg_rvalid === 1'b1 ? reg_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the nv default register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import nvdr_pkg::*;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fault_record, adc_alarm_record, q;
  logic       reg_wr, reg_rd, reg_rvalid, reg_hit, wr_refused, fault_log_en;
  logic       restore_fault_en, reboot_req, restart_en, load_defaults;
  logic       restore_fault, host_ready, core_off, restart, nv_busy;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic [NVDR_NUM_BYTES-1:0][7:0] nv_image;
  int         n_errors = 0;
  int         n_tests = 0;
  int         k;
  // rows: address in the upper byte, shipped value in the lower
  logic [15:0] rows [14] = '{16'h2200, 16'h2300, 16'h2400, 16'h2500,
    16'h26ff, 16'h2700, 16'h2800, 16'h29ff, 16'h2a00, 16'h2bff,
    16'h2c00, 16'h2dff, 16'h2e00, 16'h2fff};
  always #50 mclk = ~mclk;
  nvdr_bank #(.NV_WRITE_CYC(8), .REBOOT_CYC(20)) nvdr_bank_inst (.mclk,
    .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .reg_hit, .wr_refused, .fault_record, .adc_alarm_record, .fault_log_en,
    .restore_fault_en, .reboot_req, .restart_en, .nv_image, .load_defaults,
    .restore_fault, .host_ready, .core_off, .restart, .nv_busy);
  nvdr_host nvdr_host_inst (.mclk, .nv_busy, .reg_rvalid, .reg_rdata,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 30 && nv_busy !== 1'b0; i++) tick(1);
  endtask
  task automatic do_reset;
    reset = 1'b1;
    tick(12);
    reset = 1'b0;
    tick(1);
    chk("boot_load", 8'(load_defaults), 8'h01);
    chk("restore", 8'(restore_fault), 8'(restore_fault_en));
    chk("ready", 8'(host_ready), 8'h01);
  endtask
  // ==========================================================
  // sequence
  initial begin
    {fault_record, adc_alarm_record} = 16'h0;
    {fault_log_en, restore_fault_en, reboot_req, restart_en} = 4'b0101;
    do_reset;
    for (k = 0; k < 14; k++) begin
      nvdr_host_inst.rd(rows[k][15:8], q);
      chk("shipped", q, rows[k][7:0]);
      chk("hit", 8'(reg_hit), 8'h01);
      nvdr_host_inst.wr(rows[k][15:8], 8'ha5 ^ 8'(k), 1'b1);
      nvdr_host_inst.rd(rows[k][15:8], q);
      chk("read_back", q, 8'ha5 ^ 8'(k));
      chk("image", nv_image[k], 8'ha5 ^ 8'(k));
    end
    nvdr_host_inst.rd(8'h30, q);
    chk("unmapped", q, 8'h00);
    chk("unmapped_hit", 8'(reg_hit), 8'h00);
    nvdr_host_inst.wr(8'h26, 8'h3c, 1'b1);
    nvdr_host_inst.wr(8'h27, 8'hc3, 1'b0);
    chk("refused", 8'(wr_refused), 8'h01);
    chk("kept", nv_image[5], 8'ha0);
    for (k = 2; k < 30 && nv_busy === 1'b1; k++) tick(1);
    chk("busy_len", 8'(k), 8'h08);
    fault_record = 8'h04;
    tick(3);
    chk("log_off", nv_image[2], 8'ha7);
    {fault_record, fault_log_en} = 9'h001;
    tick(1);
    fault_record = 8'h04;
    tick(2);
    chk("fault_copy", nv_image[2], 8'h04);
    wait_idle;
    {fault_record, adc_alarm_record} = 16'h0081;
    tick(2);
    chk("adc_copy", nv_image[3], 8'h81);
    chk("falling", nv_image[2], 8'h04);
    wait_idle;
    reboot_req = 1'b1;
    tick(1);
    reboot_req = 1'b0;
    chk("reload", 8'({core_off, load_defaults}), 8'h03);
    for (k = 0; k < 40 && core_off === 1'b1; k++) tick(1);
    chk("off_len", 8'(k), 8'h14);
    chk("restart", 8'(restart), 8'h01);
    chk("nv_kept", nv_image[4], 8'h3c);
    restore_fault_en = 1'b0;
    do_reset;
    chk("reshipped", nv_image[4], 8'hff);
    {reboot_req, restart_en} = 2'b10;
    tick(1);
    reboot_req = 1'b0;
    for (k = 0; k < 40 && core_off === 1'b1; k++) tick(1);
    chk("off_len_quiet", 8'(k), 8'h14);
    chk("no_restart", 8'(restart), 8'h00);
    finish_test;
  end
  initial begin
    #(100 * 4000);
    n_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
